/* dv/tb_timer_clock_select.sv */
module tb_timer_clock_select;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst_b, sfr_we, ext_clk, ext_en, clr, cs0, cs1, sp2, sp3, alt, src;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0] ph = 3'h0;
    logic [5:0] ticks;
    logic [5:0][15:0] cnt;
    tcs_pkg::tcs_prescale_t pf;
    int n_mismatch = 0;
    int check_count = 0;
    // event ticks every second cycle, own-source ticks every third cycle
    assign alt = ph[0];
    assign src = (ph == 3'h0) || (ph == 3'h3);
    tcs_clock_select DUT (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_rdata(sfr_rdata), .ext_clk(ext_clk),
        .tmr0_counter_select(cs0), .tmr1_counter_select(cs1), .tmr2_split(sp2),
        .tmr3_split(sp3), .tmr0_event_tick(alt), .tmr1_event_tick(alt),
        .tmr2_src_tick(src), .tmr3_src_tick(src), .tmr0_tick(ticks[0]),
        .tmr1_tick(ticks[1]), .tmr2_low_tick(ticks[2]), .tmr2_high_tick(ticks[3]),
        .tmr3_low_tick(ticks[4]), .tmr3_high_tick(ticks[5]), .prescale_field(pf));
    tcs_timer_model timers (.clk_sys(clk_sys), .clr(clr), .ticks(ticks), .cnt(cnt));
    // system clock and a 40 ns external clock that stands still when disabled
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        ext_clk = 1'b0;
        #3;
        forever #20 ext_clk = ext_en ? ~ext_clk : 1'b0;
    end
    always @(posedge clk_sys) ph <= #1 (ph == 3'h5) ? 3'h0 : ph + 3'h1;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_we = 1'b1;
        @(posedge clk_sys);
        #1 sfr_we = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        repeat (2) @(posedge clk_sys);
        #1 chk({8'h00, sfr_rdata}, {8'h00, exp});
    endtask : rd
    // configure, let the selection settle, then count enables over a window
    task automatic measure(input logic [7:0] v, input logic s, input logic c, input int w);
        wr(8'h8E, v);
        sp2 = s;
        sp3 = s;
        cs0 = c;
        cs1 = c;
        repeat (100) @(posedge clk_sys);
        #1 clr = 1'b1;
        @(posedge clk_sys);
        #1 clr = 1'b0;
        repeat (w) @(posedge clk_sys);
        #1;
    endtask : measure
    task automatic expect6(input int e0, e1, e2, e3, e4, e5);
        chk(cnt[0], e0[15:0]);
        chk(cnt[1], e1[15:0]);
        chk(cnt[2], e2[15:0]);
        chk(cnt[3], e3[15:0]);
        chk(cnt[4], e4[15:0]);
        chk(cnt[5], e5[15:0]);
    endtask : expect6
    task automatic t_register;
        rd(8'h8E, 8'h00);
        wr(8'h8E, 8'hA5);
        rd(8'h8E, 8'hA5);
        chk({14'h0000, pf}, 16'h0001);
        wr(8'h8F, 8'h3C);
        rd(8'h8E, 8'hA5);
        rd(8'h8F, 8'h00);
        $display("test register done");
    endtask : t_register
    task automatic t_unsplit;
        measure(8'h00, 1'b0, 1'b0, 48);
        expect6(4, 4, 16, 16, 16, 16);
        measure(8'h7C, 1'b0, 1'b0, 48);
        expect6(48, 48, 48, 48, 48, 48);
        $display("test unsplit done");
    endtask : t_unsplit
    task automatic t_counter_mode;
        measure(8'h8C, 1'b0, 1'b1, 48);
        expect6(24, 24, 16, 16, 16, 16);
        $display("test counter mode done");
    endtask : t_counter_mode
    task automatic t_split;
        measure(8'hA0, 1'b1, 1'b0, 48);
        expect6(4, 4, 16, 48, 16, 48);
        measure(8'h50, 1'b1, 1'b0, 48);
        expect6(4, 4, 48, 16, 48, 16);
        $display("test split done");
    endtask : t_split
    task automatic t_prescale;
        measure(8'h01, 1'b0, 1'b0, 48);
        expect6(12, 12, 16, 16, 16, 16);
        measure(8'h02, 1'b0, 1'b0, 48);
        expect6(1, 1, 16, 16, 16, 16);
        $display("test prescale done");
    endtask : t_prescale
    task automatic t_ext;
        ext_en = 1'b1;
        measure(8'h03, 1'b0, 1'b0, 256);
        chk(cnt[0], 16'h0008);
        chk(cnt[1], 16'h0008);
        ext_en = 1'b0;
        measure(8'h03, 1'b0, 1'b0, 256);
        chk(cnt[0], 16'h0000);
        $display("test external clock done");
    endtask : t_ext
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    // watchdog: the full sequence needs about 18 us
    initial begin
        #200us;
        n_mismatch++;
        results();
    end
    // reset, then the scenarios in turn
    initial begin
        rst_b = 1'b0;
        sfr_we = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        ext_en = 1'b0;
        clr = 1'b0;
        {cs0, cs1, sp2, sp3} = 4'h0;
        repeat (2) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        t_register();
        t_unsplit();
        t_counter_mode();
        t_split();
        t_prescale();
        t_ext();
        results();
    end
endmodule : tb_timer_clock_select

/* dv/tcs_timer_model.sv */
module tcs_timer_model (
    // clock and count clear
    input wire logic clk_sys,
    input wire logic clr,
    // count enables from the selector
    input wire logic [5:0] ticks,
    // accumulated count per timer enable
    output logic [5:0][15:0] cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0][15:0] cnt_next;
    // each timer advances once per enabled system clock edge, never on a derived clock
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            cnt_next[i] = clr ? 16'h0000 : cnt[i] + {15'h0000, ticks[i]};
        end
    end
    // register the counts
    always_ff @(posedge clk_sys) begin
        cnt <= cnt_next;
    end
endmodule : tcs_timer_model

/* rtl/tcs_clock_select.sv */
`include "tcs_defs.svh"

module tcs_clock_select (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    output logic [7:0] sfr_rdata,
    // external clock pin
    input wire logic ext_clk,
    // timer configuration from timer logic
    input wire logic tmr0_counter_select,
    input wire logic tmr1_counter_select,
    input wire logic tmr2_split,
    input wire logic tmr3_split,
    // count pulses from timer logic
    input wire logic tmr0_event_tick,
    input wire logic tmr1_event_tick,
    input wire logic tmr2_src_tick,
    input wire logic tmr3_src_tick,
    // count enables to the timers, and the prescale field
    output logic tmr0_tick,
    output logic tmr1_tick,
    output logic tmr2_low_tick,
    output logic tmr2_high_tick,
    output logic tmr3_low_tick,
    output logic tmr3_high_tick,
    output tcs_pkg::tcs_prescale_t prescale_field
);
    import tcs_pkg::*;

    logic [7:0] timer_clock_control_reg, timer_clock_control_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [5:0] tick_reg, tick_next;
    logic tmr3_high_clk_sel, tmr3_low_clk_sel, tmr2_high_clk_sel, tmr2_low_clk_sel;
    logic tmr1_clk_sel, tmr0_clk_sel;
    logic t2_low, t3_low;

    tcs_presc_if pif ();

    tcs_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ext_clk(ext_clk),
        .pif(pif)
    );

    // field decode
    assign tmr3_high_clk_sel = timer_clock_control_reg[`TCS_T3_HI_SEL_BIT];
    assign tmr3_low_clk_sel = timer_clock_control_reg[`TCS_T3_LO_SEL_BIT];
    assign tmr2_high_clk_sel = timer_clock_control_reg[`TCS_T2_HI_SEL_BIT];
    assign tmr2_low_clk_sel = timer_clock_control_reg[`TCS_T2_LO_SEL_BIT];
    assign tmr1_clk_sel = timer_clock_control_reg[`TCS_T1_SEL_BIT];
    assign tmr0_clk_sel = timer_clock_control_reg[`TCS_T0_SEL_BIT];
    assign pif.prescale_field = tcs_prescale_t'(timer_clock_control_reg[`TCS_PS_MSB:`TCS_PS_LSB]);

    // register write and read data
    always_comb begin
        timer_clock_control_next = timer_clock_control_reg;
        if (sfr_we && sfr_addr == `TCS_CTRL_ADDR) begin
            timer_clock_control_next = sfr_wdata;
        end
        rdata_next = (sfr_addr == `TCS_CTRL_ADDR) ? timer_clock_control_reg : 8'h00;
    end

    // count enable selection, all in the system clock domain
    always_comb begin
        t2_low = tmr2_low_clk_sel ? 1'b1 : tmr2_src_tick;
        t3_low = tmr3_low_clk_sel ? 1'b1 : tmr3_src_tick;
        // timer 0 and timer 1
        tick_next[0] = tmr0_counter_select ? tmr0_event_tick :
            (tmr0_clk_sel ? 1'b1 : pif.presc_tick);
        tick_next[1] = tmr1_counter_select ? tmr1_event_tick :
            (tmr1_clk_sel ? 1'b1 : pif.presc_tick);
        tick_next[2] = t2_low;
        tick_next[3] = tmr2_split ? (tmr2_high_clk_sel ? 1'b1 : tmr2_src_tick) : t2_low;
        tick_next[4] = t3_low;
        tick_next[5] = tmr3_split ? (tmr3_high_clk_sel ? 1'b1 : tmr3_src_tick) : t3_low;
    end

    // registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timer_clock_control_reg <= `TCS_CTRL_RESET;
            rdata_reg <= 8'h00;
            tick_reg <= 6'h00;
        end else begin
            timer_clock_control_reg <= timer_clock_control_next;
            rdata_reg <= rdata_next;
            tick_reg <= tick_next;
        end
    end

    // outputs straight from flip-flops
    assign sfr_rdata = rdata_reg;
    assign tmr0_tick = tick_reg[0];
    assign tmr1_tick = tick_reg[1];
    assign tmr2_low_tick = tick_reg[2];
    assign tmr2_high_tick = tick_reg[3];
    assign tmr3_low_tick = tick_reg[4];
    assign tmr3_high_tick = tick_reg[5];
    assign prescale_field = tcs_prescale_t'(timer_clock_control_reg[`TCS_PS_MSB:`TCS_PS_LSB]);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence sfr_write_s;
        sfr_we && sfr_addr == `TCS_CTRL_ADDR;
    endsequence

    t3_high_split_a: assert property ($past(tmr3_split) && $past(tmr3_high_clk_sel)
        |-> tmr3_high_tick) else $error("timer 3 high byte not on system clock");
    t3_whole_a: assert property (!tmr3_split ##1 1
        |-> tmr3_high_tick == tmr3_low_tick) else $error("timer 3 unsplit clocks differ");
    t3_low_sys_a: assert property ($past(tmr3_low_clk_sel) |-> tmr3_low_tick)
        else $error("timer 3 low not on system clock");
    t2_high_src_a: assert property (tmr2_split && !tmr2_high_clk_sel
        |=> tmr2_high_tick == $past(tmr2_src_tick)) else $error("timer 2 high source wrong");
    t2_high_sys_a: assert property (tmr2_split && tmr2_high_clk_sel |=> tmr2_high_tick)
        else $error("timer 2 high not on system clock");
    t2_low_src_a: assert property (!tmr2_low_clk_sel
        |=> tmr2_low_tick == $past(tmr2_src_tick)) else $error("timer 2 low source wrong");
    t2_low_sys_a: assert property (tmr2_low_clk_sel |=> tmr2_low_tick)
        else $error("timer 2 low not on system clock");
    t1_counter_a: assert property (tmr1_counter_select
        |=> tmr1_tick == $past(tmr1_event_tick)) else $error("timer 1 event count wrong");
    t1_timer_a: assert property (!tmr1_counter_select && !tmr1_clk_sel
        |=> tmr1_tick == $past(pif.presc_tick)) else $error("timer 1 prescaled clock wrong");
    t0_counter_a: assert property (tmr0_counter_select
        |=> tmr0_tick == $past(tmr0_event_tick)) else $error("timer 0 event count wrong");
    t0_timer_a: assert property (!tmr0_counter_select
        |=> tmr0_tick == ($past(tmr0_clk_sel) ? 1'b1 : $past(pif.presc_tick)))
        else $error("timer 0 clock wrong");
    sfr_store_a: assert property (sfr_write_s ##1 !sfr_we [*2]
        |-> timer_clock_control_reg == $past(sfr_wdata, 2)) else $error("register write lost");
    sfr_read_a: assert property (sfr_addr == `TCS_CTRL_ADDR ##1 1
        |-> sfr_rdata == $past(timer_clock_control_reg)) else $error("register read wrong");
endmodule : tcs_clock_select

/* rtl/tcs_defs.svh */
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// register location and reset value
`define TCS_CTRL_ADDR 8'h8E
`define TCS_CTRL_RESET 8'h00

// field positions of timer_clock_control
`define TCS_T3_HI_SEL_BIT 7
`define TCS_T3_LO_SEL_BIT 6
`define TCS_T2_HI_SEL_BIT 5
`define TCS_T2_LO_SEL_BIT 4
`define TCS_T1_SEL_BIT 3
`define TCS_T0_SEL_BIT 2
`define TCS_PS_MSB 1
`define TCS_PS_LSB 0

// division ratios of the shared prescaler
`define TCS_DIV_ENC0 6'h0C
`define TCS_DIV_ENC1 6'h04
`define TCS_DIV_ENC2 6'h30
`define TCS_EXT_DIV_LAST 3'h7

`endif

/* rtl/tcs_pkg.sv */
package tcs_pkg;
    // prescale field encodings
    typedef enum logic [1:0] {
        TCS_PS_SYS12 = 2'b00,
        TCS_PS_SYS4 = 2'b01,
        TCS_PS_SYS48 = 2'b10,
        TCS_PS_EXT8 = 2'b11
    } tcs_prescale_t;
endpackage : tcs_pkg

/* rtl/tcs_presc_if.sv */
interface tcs_presc_if;
    tcs_pkg::tcs_prescale_t prescale_field;
    logic presc_tick;
    modport ctrl (output prescale_field, input presc_tick);
    modport prescaler (input prescale_field, output presc_tick);
endinterface : tcs_presc_if

/* rtl/tcs_prescaler.sv */
`include "tcs_defs.svh"

module tcs_prescaler (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // external clock pin
    input wire logic ext_clk,
    // control side
    tcs_presc_if.prescaler pif
);
    import tcs_pkg::*;

    logic sync1_reg, sync1_next;
    logic sync2_reg, sync2_next;
    logic edge_reg, edge_next;
    logic [5:0] div_cnt_reg, div_cnt_next;
    logic [2:0] ext_cnt_reg, ext_cnt_next;
    logic tick_reg, tick_next;
    logic ext_rise;

    // division ratio for the system clock encodings
    function automatic logic [5:0] tcs_div_limit(input tcs_prescale_t sel);
        case (sel)
            TCS_PS_SYS12: tcs_div_limit = `TCS_DIV_ENC0;
            TCS_PS_SYS4: tcs_div_limit = `TCS_DIV_ENC1;
            TCS_PS_SYS48: tcs_div_limit = `TCS_DIV_ENC2;
            default: tcs_div_limit = `TCS_DIV_ENC0;
        endcase
    endfunction : tcs_div_limit

    // next state: synchroniser, edge detect, dividers
    always_comb begin
        sync1_next = ext_clk;
        sync2_next = sync1_reg;
        edge_next = sync2_reg;
        ext_rise = sync2_reg & ~edge_reg;
        div_cnt_next = div_cnt_reg;
        ext_cnt_next = ext_cnt_reg;
        tick_next = 1'b0;
        if (pif.prescale_field == TCS_PS_EXT8) begin
            div_cnt_next = 6'h00; // no stale count can tick early on a switch back
            if (ext_rise) begin
                ext_cnt_next = ext_cnt_reg + 3'h1;
                tick_next = (ext_cnt_reg == `TCS_EXT_DIV_LAST);
            end
        end else if (div_cnt_reg >= tcs_div_limit(pif.prescale_field) - 6'h01) begin
            ext_cnt_next = 3'h0; // external path restarts a full group of eight
            div_cnt_next = 6'h00;
            tick_next = 1'b1;
        end else begin
            ext_cnt_next = 3'h0;
            div_cnt_next = div_cnt_reg + 6'h01;
        end
    end

    // registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            edge_reg <= 1'b0;
            div_cnt_reg <= 6'h00;
            ext_cnt_reg <= 3'h0;
            tick_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            edge_reg <= edge_next;
            div_cnt_reg <= div_cnt_next;
            ext_cnt_reg <= ext_cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign pif.presc_tick = tick_reg;

    // at most one tick per four system clocks while a system ratio is kept
    sequence ps_quiet3_s;
        !tick_reg [*3];
    endsequence
    presc_spacing_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tick_reg && pif.prescale_field != TCS_PS_EXT8 |=> ps_quiet3_s)
        else $error("prescaler ticks closer than four cycles");

    // external tick only follows a synchronised rising edge
    ext_sync_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(tick_reg) && $past(pif.prescale_field) == TCS_PS_EXT8
        |-> $past(sync2_reg) && !$past(edge_reg))
        else $error("external tick without synchronised edge");
endmodule : tcs_prescaler
